// ### src/cbfx_exec.sv
// Operation
// RULE1: transfer clear branch: pc+k+1, 1/2 cycles
// RULE2: overflow set/clear branches jump pc+k+1
// RULE3: irq enabled/disabled branches, flags untouched
// RULE4: io bit set/clear, two cycles
// RULE5: left shift/rotate updates Z C N V
// RULE6: right rotate/shifts update Z C N V
// RULE7: bit to/from transfer flag, one cycle
// RULE8: set/clear any single status flag
// RULE9: moves, immediates, swaps: one cycle, flags kept
// RULE10: indirect load via pointer pair, two cycles
module cbfx_exec
  import cbfx_pkg::*;
#(
  parameter int PC_W = 16
)
(
  // clock and reset
  input  wire logic            CLK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic            CE_I,
  // instruction from fetch
  input  wire logic            INSTR_VALID_I,
  input  wire cbfx_pkg::cbfx_op_t OP_I,
  input  wire logic [4:0]      DST_I,
  input  wire logic [4:0]      SRC_I,
  input  wire logic [2:0]      BIT_I,
  input  wire logic [7:0]      IMM_I,
  input  wire logic [6:0]      OFFSET_I,
  input  wire logic [4:0]      IO_ADDR_I,
  output logic                 READY_O,
  output logic [PC_W-1:0]      PC_O,
  output logic [7:0]           STATUS_FLAGS_WORD_O,
  // io space
  output logic                 IO_RD_O,
  output logic                 IO_WR_O,
  output logic [4:0]           IO_ADDR_O,
  output logic [7:0]           IO_WDATA_O,
  input  wire logic [7:0]      IO_RDATA_I,
  // data space
  output logic                 DM_RD_O,
  output logic [15:0]          DM_ADDR_O,
  input  wire logic [7:0]      DM_RDATA_I,
  // register observation
  input  wire logic [4:0]      REG_SEL_I,
  output logic [7:0]           REG_DATA_O
);

  if (PC_W < 8 || PC_W > 22)
  begin : g_bad_pc_w
    $error("PC_W out of range");
  end

  logic [7:0]      regs_r [32];
  logic [PC_W-1:0] pc_r,        pc_nxt;
  logic [7:0]      status_flags_word_r,      status_flags_word_nxt;
  cbfx_state_t     state_r,     state_nxt;
  logic            ready_r,     ready_nxt;
  logic            io_rd_r,     io_rd_nxt;
  logic            io_wr_r,     io_wr_nxt;
  logic [4:0]      io_addr_r,   io_addr_nxt;
  logic [7:0]      io_wdata_r,  io_wdata_nxt;
  logic            dm_rd_r,     dm_rd_nxt;
  logic [15:0]     dm_addr_r,   dm_addr_nxt;
  logic [4:0]      pend_dst_r,  pend_dst_nxt;
  logic [2:0]      pend_bit_r,  pend_bit_nxt;
  logic            pend_set_r,  pend_set_nxt;
  logic [7:0]      reg_obs_r;
  logic            wr_en;
  logic [4:0]      wr_addr;
  logic [7:0]      wr_data;
  logic            wr2_en;
  logic [7:0]      wr2_data;
  logic [7:0]      rd_val;
  logic [7:0]      rr_val;
  logic [7:0]      bit_mask;
  logic [7:0]      sh_res;
  logic            sh_z;
  logic            sh_c;
  logic            sh_n;
  logic            sh_v;
  logic            br_take;
  logic            accept;
  logic [PC_W-1:0] rel_target;

  assign rd_val     = regs_r[DST_I];
  assign rr_val     = regs_r[SRC_I];
  assign bit_mask   = 8'h01 << BIT_I;
  assign accept     = CE_I && INSTR_VALID_I && ready_r;
  assign rel_target = pc_r + PC_W'({{(PC_W-7){OFFSET_I[6]}}, OFFSET_I}) + PC_W'(1);

  cbfx_shift u_shift (
    .op_i    (OP_I),
    .data_i  (rd_val),
    .carry_i (status_flags_word_r[SF_C]),
    .res_o   (sh_res),
    .z_o     (sh_z),
    .c_o     (sh_c),
    .n_o     (sh_n),
    .v_o     (sh_v)
  );

  always_comb
  begin
    unique case (OP_I)
      OP_BRANCH_ON_TRANSFER_CLEAR: br_take = !status_flags_word_r[SF_T]; // see RULE1
      OP_BRANCH_ON_OVERFLOW_SET:   br_take = status_flags_word_r[SF_V];  // see RULE2
      OP_BRANCH_ON_OVERFLOW_CLEAR: br_take = !status_flags_word_r[SF_V]; // see RULE2
      OP_BRANCH_ON_IRQ_ENABLED:    br_take = status_flags_word_r[SF_I];  // see RULE3
      OP_BRANCH_ON_IRQ_DISABLED:   br_take = !status_flags_word_r[SF_I]; // see RULE3
      default:                     br_take = 1'b0;
    endcase
  end

  always_comb
  begin
    pc_nxt       = pc_r;
    status_flags_word_nxt     = status_flags_word_r;
    state_nxt    = state_r;
    ready_nxt    = ready_r;
    io_rd_nxt    = 1'b0;
    io_wr_nxt    = 1'b0;
    io_addr_nxt  = io_addr_r;
    io_wdata_nxt = io_wdata_r;
    dm_rd_nxt    = 1'b0;
    dm_addr_nxt  = dm_addr_r;
    pend_dst_nxt = pend_dst_r;
    pend_bit_nxt = pend_bit_r;
    pend_set_nxt = pend_set_r;
    wr_en        = 1'b0;
    wr_addr      = DST_I;
    wr_data      = 8'h00;
    wr2_en       = 1'b0;
    wr2_data     = 8'h00;
    unique case (state_r)
      ST_EXEC:
      begin
        if (INSTR_VALID_I)
        begin
          pc_nxt = pc_r + PC_W'(1);
          unique case (OP_I)
            OP_BRANCH_ON_TRANSFER_CLEAR, OP_BRANCH_ON_OVERFLOW_SET, OP_BRANCH_ON_OVERFLOW_CLEAR,
            OP_BRANCH_ON_IRQ_ENABLED, OP_BRANCH_ON_IRQ_DISABLED:
            begin
              if (br_take)
              begin
                pc_nxt    = rel_target; // see RULE1, RULE2, RULE3
                state_nxt = ST_BR_WAIT;
                ready_nxt = 1'b0;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
            begin
              io_rd_nxt    = 1'b1; // see RULE4
              io_addr_nxt  = IO_ADDR_I;
              pend_bit_nxt = BIT_I;
              pend_set_nxt = (OP_I == OP_IO_BIT_SET);
              state_nxt    = ST_IO_MOD;
              ready_nxt    = 1'b0;
            end
            OP_LOGICAL_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY, OP_LOGICAL_SHIFT_RIGHT,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT:
            begin
              wr_en          = 1'b1; // see RULE5, RULE6
              wr_data        = sh_res;
              status_flags_word_nxt[SF_Z] = sh_z;
              status_flags_word_nxt[SF_C] = sh_c;
              status_flags_word_nxt[SF_N] = sh_n;
              status_flags_word_nxt[SF_V] = sh_v;
            end
            OP_BIT_TO_TRANSFER_FLAG:
              status_flags_word_nxt[SF_T] = rr_val[BIT_I]; // see RULE7
            OP_TRANSFER_FLAG_TO_BIT:
            begin
              wr_en   = 1'b1;
              wr_data = status_flags_word_r[SF_T] ? (rd_val | bit_mask) : (rd_val & ~bit_mask); // see RULE7
            end
            OP_FLAG_SET:
              status_flags_word_nxt = status_flags_word_r | bit_mask; // see RULE8
            OP_FLAG_CLEAR:
              status_flags_word_nxt = status_flags_word_r & ~bit_mask; // see RULE8
            OP_COPY_REGISTER_BYTE:
            begin
              wr_en   = 1'b1; // see RULE9
              wr_data = rr_val;
            end
            OP_COPY_REGISTER_PAIR:
            begin
              wr_en    = 1'b1; // see RULE9
              wr_addr  = {DST_I[4:1], 1'b0};
              wr_data  = regs_r[{SRC_I[4:1], 1'b0}];
              wr2_en   = 1'b1;
              wr2_data = regs_r[{SRC_I[4:1], 1'b1}];
            end
            OP_LOAD_IMMEDIATE:
            begin
              wr_en   = 1'b1; // see RULE9
              wr_data = IMM_I;
            end
            OP_SWAP_NIBBLES:
            begin
              wr_en   = 1'b1; // see RULE9
              wr_data = {rd_val[3:0], rd_val[7:4]};
            end
            OP_LOAD_INDIRECT:
            begin
              dm_rd_nxt    = 1'b1; // see RULE10
              dm_addr_nxt  = {regs_r[PTR_HI_IDX], regs_r[PTR_LO_IDX]};
              pend_dst_nxt = DST_I;
              state_nxt    = ST_LD_FILL;
              ready_nxt    = 1'b0;
            end
            default:
            begin
            end
          endcase
        end
      end
      ST_BR_WAIT:
      begin
        state_nxt = ST_EXEC;
        ready_nxt = 1'b1;
      end
      ST_IO_MOD:
      begin
        io_wr_nxt    = 1'b1; // see RULE4
        io_wdata_nxt = pend_set_r ? (IO_RDATA_I | (8'h01 << pend_bit_r))
                                  : (IO_RDATA_I & ~(8'h01 << pend_bit_r));
        state_nxt    = ST_EXEC;
        ready_nxt    = 1'b1;
      end
      ST_LD_FILL:
      begin
        wr_en     = 1'b1; // see RULE10
        wr_addr   = pend_dst_r;
        wr_data   = DM_RDATA_I;
        state_nxt = ST_EXEC;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      pc_r       <= '0;
      status_flags_word_r     <= STATUS_FLAGS_WORD_RST;
      state_r    <= ST_EXEC;
      ready_r    <= 1'b1;
      io_rd_r    <= 1'b0;
      io_wr_r    <= 1'b0;
      io_addr_r  <= 5'h00;
      io_wdata_r <= 8'h00;
      dm_rd_r    <= 1'b0;
      dm_addr_r  <= 16'h0000;
      pend_dst_r <= 5'h00;
      pend_bit_r <= 3'h0;
      pend_set_r <= 1'b0;
      reg_obs_r  <= REG_RST;
    end
    else if (CE_I)
    begin
      pc_r       <= pc_nxt;
      status_flags_word_r     <= status_flags_word_nxt;
      state_r    <= state_nxt;
      ready_r    <= ready_nxt;
      io_rd_r    <= io_rd_nxt;
      io_wr_r    <= io_wr_nxt;
      io_addr_r  <= io_addr_nxt;
      io_wdata_r <= io_wdata_nxt;
      dm_rd_r    <= dm_rd_nxt;
      dm_addr_r  <= dm_addr_nxt;
      pend_dst_r <= pend_dst_nxt;
      pend_bit_r <= pend_bit_nxt;
      pend_set_r <= pend_set_nxt;
      reg_obs_r  <= regs_r[REG_SEL_I];
    end
  end

  // register file
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      for (int i = 0; i < 32; i++)
        regs_r[i] <= REG_RST;
    end
    else if (CE_I)
    begin
      if (wr_en)
        regs_r[wr_addr] <= wr_data;
      if (wr2_en)
        regs_r[wr_addr | 5'h01] <= wr2_data;
    end
  end

  assign READY_O    = ready_r;
  assign PC_O       = pc_r;
  assign STATUS_FLAGS_WORD_O     = status_flags_word_r;
  assign IO_RD_O    = io_rd_r;
  assign IO_WR_O    = io_wr_r;
  assign IO_ADDR_O  = io_addr_r;
  assign IO_WDATA_O = io_wdata_r;
  assign DM_RD_O    = dm_rd_r;
  assign DM_ADDR_O  = dm_addr_r;
  assign REG_DATA_O = reg_obs_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I || !CE_I);

  sequence s_long_done;
    !ready_r ##1 ready_r;
  endsequence

  a_tclr_taken: assert property (accept && OP_I == OP_BRANCH_ON_TRANSFER_CLEAR && !status_flags_word_r[SF_T] // see RULE1
    |=> pc_r == $past(rel_target) ##0 s_long_done)
    else $error("taken transfer branch wrong target or timing");
  a_tclr_not_taken: assert property (accept && OP_I == OP_BRANCH_ON_TRANSFER_CLEAR && status_flags_word_r[SF_T] // see RULE1
    |=> ready_r && pc_r == $past(pc_r) + PC_W'(1))
    else $error("untaken transfer branch not single cycle");
  a_ovf_branch: assert property (accept && (OP_I == OP_BRANCH_ON_OVERFLOW_SET) // see RULE2
    |=> pc_r == ($past(status_flags_word_r[SF_V]) ? $past(rel_target) : $past(pc_r) + PC_W'(1)))
    else $error("overflow branch decision wrong");
  a_irq_branch_flags: assert property (accept && (OP_I == OP_BRANCH_ON_IRQ_DISABLED) // see RULE3
    |=> status_flags_word_r == $past(status_flags_word_r) && (ready_r == $past(status_flags_word_r[SF_I])))
    else $error("irq branch changed flags or wrong timing");
  a_io_bit_seq: assert property (accept && OP_I == OP_IO_BIT_SET // see RULE4
    |=> io_rd_r && !io_wr_r ##1 io_wr_r && !io_rd_r && io_wdata_r[pend_bit_r] && ready_r)
    else $error("io bit set sequence wrong");
  a_rol_carry: assert property (accept && OP_I == OP_ROTATE_LEFT_CARRY // see RULE5
    |=> status_flags_word_r[SF_C] == $past(rd_val[7]) && regs_r[$past(DST_I)][0] == $past(status_flags_word_r[SF_C]))
    else $error("rotate left carry path wrong");
  a_asr_keep_msb: assert property (accept && OP_I == OP_ARITH_SHIFT_RIGHT // see RULE6
    |=> regs_r[$past(DST_I)][7] == $past(rd_val[7]) && status_flags_word_r[SF_C] == $past(rd_val[0]))
    else $error("arithmetic shift right wrong");
  a_bit_to_t: assert property (accept && OP_I == OP_BIT_TO_TRANSFER_FLAG // see RULE7
    |=> status_flags_word_r[SF_T] == $past(rr_val[BIT_I]) && ready_r)
    else $error("bit to transfer flag wrong");
  a_flag_single: assert property (accept && OP_I == OP_FLAG_CLEAR // see RULE8
    |=> status_flags_word_r == ($past(status_flags_word_r) & ~$past(bit_mask)))
    else $error("flag clear touched other flags");
  a_move_flags: assert property (accept && OP_I == OP_LOAD_IMMEDIATE // see RULE9
    |=> status_flags_word_r == $past(status_flags_word_r) && ready_r && regs_r[$past(DST_I)] == $past(IMM_I))
    else $error("immediate load wrong");
  a_ld_two_cyc: assert property (accept && OP_I == OP_LOAD_INDIRECT // see RULE10
    |=> dm_rd_r and s_long_done)
    else $error("indirect load timing wrong");

endmodule

// ### src/cbfx_pkg.sv
package cbfx_pkg;

  // status word bit positions
  localparam int SF_C = 0;
  localparam int SF_Z = 1;
  localparam int SF_N = 2;
  localparam int SF_V = 3;
  localparam int SF_S = 4;
  localparam int SF_H = 5;
  localparam int SF_T = 6;
  localparam int SF_I = 7;

  // reset values
  localparam logic [7:0] STATUS_FLAGS_WORD_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  // pointer pair used by load_indirect (high:low register index)
  localparam logic [4:0] PTR_LO_IDX = 5'h1a;
  localparam logic [4:0] PTR_HI_IDX = 5'h1b;

  // cycle counts
  localparam int CYC_SHORT = 1;
  localparam int CYC_LONG  = 2;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_ON_TRANSFER_CLEAR,
    OP_BRANCH_ON_OVERFLOW_SET,
    OP_BRANCH_ON_OVERFLOW_CLEAR,
    OP_BRANCH_ON_IRQ_ENABLED,
    OP_BRANCH_ON_IRQ_DISABLED,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGICAL_SHIFT_LEFT,
    OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_FLAG_SET,
    OP_FLAG_CLEAR,
    OP_COPY_REGISTER_BYTE,
    OP_COPY_REGISTER_PAIR,
    OP_LOAD_IMMEDIATE,
    OP_SWAP_NIBBLES,
    OP_LOAD_INDIRECT
  } cbfx_op_t;

  typedef enum logic [1:0] {
    ST_EXEC,
    ST_BR_WAIT,
    ST_IO_MOD,
    ST_LD_FILL
  } cbfx_state_t;

endpackage

// ### src/cbfx_shift.sv
module cbfx_shift
  import cbfx_pkg::*;
(
  // operation and operand
  input  wire cbfx_op_t   op_i,
  input  wire logic [7:0] data_i,
  input  wire logic       carry_i,
  // result and flags
  output logic      [7:0] res_o,
  output logic            z_o,
  output logic            c_o,
  output logic            n_o,
  output logic            v_o
);

  always_comb
  begin
    res_o = data_i;
    c_o   = carry_i;
    unique case (op_i)
      OP_LOGICAL_SHIFT_LEFT:
      begin
        res_o = {data_i[6:0], 1'b0};
        c_o   = data_i[7];
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        res_o = {data_i[6:0], carry_i};
        c_o   = data_i[7];
      end
      OP_LOGICAL_SHIFT_RIGHT:
      begin
        res_o = {1'b0, data_i[7:1]};
        c_o   = data_i[0];
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        res_o = {carry_i, data_i[7:1]};
        c_o   = data_i[0];
      end
      OP_ARITH_SHIFT_RIGHT:
      begin
        res_o = {data_i[7], data_i[7:1]};
        c_o   = data_i[0];
      end
      default:
      begin
        res_o = data_i;
        c_o   = carry_i;
      end
    endcase
    z_o = (res_o == 8'h00);
    n_o = res_o[7];
    v_o = res_o[7] ^ c_o;
  end

endmodule

// ### verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cbfx_pkg::*;

  logic            clk, rst, ce, vld;
  cbfx_op_t        op;
  logic [4:0]      dst, src, ioa, rsel;
  logic [2:0]      bt;
  logic [7:0]      imm, iord, dmrd;
  logic [6:0]      off;
  logic            rdy, io_rd, io_wr, dm_rd;
  logic [15:0]     pc, dma;
  logic [7:0]      status_flags_word, iowd, rdat;
  logic [4:0]      ioao;
  int              fail_count, n_checks;
  logic [15:0]     exp_pc;
  logic [7:0]      exp_status_flags_word;
  logic            s_iord, s_iowr, s_dmrd;
  logic [4:0]      s_ioa;
  logic [7:0]      s_iowd;
  logic [15:0]     s_dma;

  cbfx_exec #(.PC_W(16)) uut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .INSTR_VALID_I(vld), .OP_I(op),
    .DST_I(dst), .SRC_I(src), .BIT_I(bt), .IMM_I(imm), .OFFSET_I(off),
    .IO_ADDR_I(ioa), .READY_O(rdy), .PC_O(pc), .STATUS_FLAGS_WORD_O(status_flags_word),
    .IO_RD_O(io_rd), .IO_WR_O(io_wr), .IO_ADDR_O(ioao), .IO_WDATA_O(iowd),
    .IO_RDATA_I(iord), .DM_RD_O(dm_rd), .DM_ADDR_O(dma), .DM_RDATA_I(dmrd),
    .REG_SEL_I(rsel), .REG_DATA_O(rdat)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one instruction; caller sets exp_pc and exp_status_flags_word beforehand
  task automatic issue(input cbfx_op_t o, input logic [4:0] d, input logic [4:0] s, input logic [2:0] b,
                       input logic [7:0] im, input logic [6:0] k, input logic [4:0] a, input int el);
    int lows;
    @(posedge clk);
    vld <= 1'b1; op <= o; dst <= d; src <= s; bt <= b; imm <= im; off <= k; ioa <= a;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    lows = (rdy === 1'b1) ? 0 : 1;
    s_iord = io_rd; s_ioa = ioao; s_dmrd = dm_rd; s_dma = dma;
    @(posedge clk);
    #1;
    s_iowr = io_wr; s_iowd = iowd;
    while (rdy !== 1'b1)
    begin
      @(posedge clk);
      #1;
      lows++;
      if (lows > 8)
      begin
        fail_count++;
        $display("[FAIL] %0t ready never returned", $time);
        summarize();
      end
    end
    chk(16'(lows), 16'(el));
    chk(pc, exp_pc);
    chk(status_flags_word, exp_status_flags_word);
  endtask

  task automatic flag(input bit v, input int i);
    exp_status_flags_word[i] = v;
    exp_pc++;
    issue(v ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 5'h00, i[2:0], 8'h00, 7'h00, 5'h00, 0);
  endtask

  task automatic li(input logic [4:0] r, input logic [7:0] v);
    exp_pc++;
    issue(OP_LOAD_IMMEDIATE, r, 5'h00, 3'h0, v, 7'h00, 5'h00, 0);
  endtask

  task automatic rop(input cbfx_op_t o, input logic [4:0] d, input logic [4:0] s, input logic [2:0] b);
    exp_pc++;
    issue(o, d, s, b, 8'h00, 7'h00, 5'h00, 0);
  endtask

  task automatic rreg(input logic [4:0] r, output logic [7:0] v);
    @(posedge clk);
    rsel <= r;
    @(posedge clk);
    @(posedge clk);
    #1;
    v = rdat;
  endtask

  task automatic t_reset();
    chk(pc, 16'h0000);
    chk(status_flags_word, 8'h00);
    chk(rdy, 1'b1);
    chk({io_rd, io_wr, dm_rd}, 3'h0);
    $display("test reset done");
  endtask

  task automatic t_flags();
    for (int i = 0; i < 8; i++) flag(1'b1, i);
    for (int i = 0; i < 8; i++) flag(1'b0, i);
    $display("test flags done");
  endtask

  task automatic t_branch();
    cbfx_op_t bo [5] = '{OP_BRANCH_ON_TRANSFER_CLEAR, OP_BRANCH_ON_OVERFLOW_SET,
                         OP_BRANCH_ON_OVERFLOW_CLEAR, OP_BRANCH_ON_IRQ_ENABLED, OP_BRANCH_ON_IRQ_DISABLED};
    int fi [5] = '{SF_T, SF_V, SF_V, SF_I, SF_I};
    bit wh [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [6:0] k;
    bit tk;
    for (int i = 0; i < 5; i++)
      for (int f = 0; f < 2; f++)
      begin
        flag(f[0], fi[i]);
        k = f[0] ? 7'h7d : 7'h06;
        tk = (f[0] == wh[i]);
        exp_pc = exp_pc + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
        issue(bo[i], 5'h00, 5'h00, 3'h0, 8'h00, k, 5'h00, tk ? 1 : 0);
      end
    $display("test branch done");
  endtask

  task automatic t_moves();
    logic [7:0] g;
    li(5'h01, 8'ha5);
    li(5'h02, 8'h3c);
    rop(OP_COPY_REGISTER_BYTE, 5'h03, 5'h01, 3'h0);
    rop(OP_SWAP_NIBBLES, 5'h03, 5'h03, 3'h0);
    rop(OP_COPY_REGISTER_PAIR, 5'h04, 5'h02, 3'h0);
    rreg(5'h03, g);
    chk(g, 8'h5a);
    rreg(5'h04, g);
    chk(g, 8'h3c);
    rreg(5'h05, g);
    chk(g, 8'h5a);
    $display("test moves done");
  endtask

  task automatic t_shift();
    cbfx_op_t so [5] = '{OP_LOGICAL_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY, OP_LOGICAL_SHIFT_RIGHT,
                         OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT};
    logic [7:0] vs [2] = '{8'h81, 8'h01};
    logic [7:0] v, r, g;
    logic c, co;
    for (int i = 0; i < 5; i++)
      for (int j = 0; j < 2; j++)
      begin
        v = vs[j];
        c = (j == 0);
        li(5'h06, v);
        flag(c, SF_C);
        case (i)
          0: begin r = {v[6:0], 1'b0}; co = v[7]; end
          1: begin r = {v[6:0], c}; co = v[7]; end
          2: begin r = {1'b0, v[7:1]}; co = v[0]; end
          3: begin r = {c, v[7:1]}; co = v[0]; end
          default: begin r = {v[7], v[7:1]}; co = v[0]; end
        endcase
        exp_status_flags_word[SF_C] = co;
        exp_status_flags_word[SF_Z] = (r == 8'h00);
        exp_status_flags_word[SF_N] = r[7];
        exp_status_flags_word[SF_V] = r[7] ^ co;
        rop(so[i], 5'h06, 5'h06, 3'h0);
        rreg(5'h06, g);
        chk(g, r);
      end
    $display("test shift done");
  endtask

  task automatic t_bits();
    logic [7:0] g;
    li(5'h07, 8'h10);
    li(5'h08, 8'h81);
    flag(1'b0, SF_T);
    exp_status_flags_word[SF_T] = 1'b1;
    rop(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h07, 3'h4);
    rop(OP_TRANSFER_FLAG_TO_BIT, 5'h08, 5'h00, 3'h6);
    exp_status_flags_word[SF_T] = 1'b0;
    rop(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h07, 3'h3);
    rop(OP_TRANSFER_FLAG_TO_BIT, 5'h08, 5'h00, 3'h7);
    rreg(5'h08, g);
    chk(g, 8'h41);
    $display("test bits done");
  endtask

  task automatic t_io();
    iord <= 8'h5a;
    exp_pc++;
    issue(OP_IO_BIT_SET, 5'h00, 5'h00, 3'h0, 8'h00, 7'h00, 5'h13, 1);
    chk({s_iord, s_ioa, s_iowr}, {1'b1, 5'h13, 1'b1});
    chk(s_iowd, 8'h5b);
    iord <= 8'hff;
    exp_pc++;
    issue(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h3, 8'h00, 7'h00, 5'h1f, 1);
    chk({s_iord, s_ioa, s_iowr}, {1'b1, 5'h1f, 1'b1});
    chk(s_iowd, 8'hf7);
    $display("test io done");
  endtask

  task automatic t_ld();
    logic [7:0] g;
    li(PTR_LO_IDX, 8'h34);
    li(PTR_HI_IDX, 8'h12);
    dmrd <= 8'hc7;
    exp_pc++;
    issue(OP_LOAD_INDIRECT, 5'h09, 5'h00, 3'h0, 8'h00, 7'h00, 5'h00, 1);
    chk({s_dmrd, s_dma}, {1'b1, 16'h1234});
    rreg(5'h09, g);
    chk(g, 8'hc7);
    $display("test load done");
  endtask

  task automatic t_ce();
    logic [7:0] g;
    @(posedge clk);
    ce <= 1'b0; vld <= 1'b1; op <= OP_LOAD_IMMEDIATE; dst <= 5'h0a; imm <= 8'h99;
    repeat (3) @(posedge clk);
    #1;
    chk(pc, exp_pc);
    chk(status_flags_word, exp_status_flags_word);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    exp_pc++;
    #1;
    chk(pc, exp_pc);
    rreg(5'h0a, g);
    chk(g, 8'h99);
    $display("test clock enable done");
  endtask

  task automatic t_rerun();
    logic [7:0] g;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    exp_pc = 16'h0000;
    exp_status_flags_word = 8'h00;
    t_reset();
    rreg(5'h09, g);
    chk(g, 8'h00);
    li(5'h0b, 8'h3e);
    rreg(5'h0b, g);
    chk(g, 8'h3e);
    $display("test second reset done");
  endtask

  initial
  begin
    rst = 1'b1; ce = 1'b1; vld = 1'b0; op = OP_NOP; dst = 5'h00; src = 5'h00;
    ioa = 5'h00; rsel = 5'h00; bt = 3'h0; imm = 8'h00; iord = 8'h00; dmrd = 8'h00; off = 7'h00;
    fail_count = 0; n_checks = 0; exp_pc = 16'h0000; exp_status_flags_word = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_flags();
    t_branch();
    t_moves();
    t_shift();
    t_bits();
    t_io();
    t_ld();
    t_ce();
    t_rerun();
    summarize();
  end
endmodule
